// ### flag_device_model.sv
// Behavioural dual-port semaphore flag device, left port on pins, right port by task
`timescale 1ns/100ps
module flag_device_model
  import flag_host_pkg::*;
(
  // Left port pins
  input  wire logic              chipSelect_n,
  input  wire logic              flag_space_select_n,
  input  wire logic              readWrite,
  input  wire logic              outEnable_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dataOut,
  input  wire logic              dataOutEn,
  output logic      [DATA_W-1:0] dataIn
);
  // ---------------------------------------------------------------------
  // Flag state: owner 0 free, 1 left, 2 right
  // ---------------------------------------------------------------------
  logic [1:0]            owner [FLAG_COUNT];
  logic [FLAG_COUNT-1:0] reqL = '0;
  logic [FLAG_COUNT-1:0] reqR = '0;
  logic                  readLatch = 1'b1;
  // Flag space is reached only with the RAM select high and the flag select low
  wire                   readAct = chipSelect_n && !flag_space_select_n && !outEnable_n;
  wire                   writeAct = chipSelect_n && !flag_space_select_n && !readWrite && dataOutEn;
  // No power-up clear: every flag starts held by the right side
  initial foreach (owner[i]) owner[i] = 2'h2;
  function automatic logic view(input bit r, input logic [INDEX_W-1:0] i);
    return (owner[i] == (r ? 2'h2 : 2'h1)) ? 1'b0 : 1'b1;
  endfunction
  task automatic put(input bit r, input logic [INDEX_W-1:0] i, input logic b);
    if (r) reqR[i] = b;
    else reqL[i] = b;
    if (owner[i] == 2'h0 && !b) owner[i] = r ? 2'h2 : 2'h1;
    else if (b && owner[i] == (r ? 2'h2 : 2'h1))
      owner[i] = (r ? reqL[i] : reqR[i]) ? 2'h0 : (r ? 2'h1 : 2'h2);
  endtask
  task automatic write_right(input logic [INDEX_W-1:0] i, input logic b);
    put(1'b1, i, b);
  endtask
  // ---------------------------------------------------------------------
  // Left port: only low index lines and data bit zero matter
  // ---------------------------------------------------------------------
  always @(posedge writeAct) put(1'b0, addr[INDEX_W-1:0], dataOut[0]);
  always @(posedge readAct) readLatch = view(1'b0, addr[INDEX_W-1:0]);
  // Released bus shows the inverse of the latched flag, never the last value
  always_comb dataIn = (readAct && readWrite) ? {DATA_W{readLatch}} : {DATA_W{~readLatch}};
endmodule

// ### flag_host_pkg.sv
// Constants for the semaphore flag port controller
package flag_host_pkg;
  localparam int FLAG_COUNT      = 8;
  localparam int INDEX_W         = 3;
  localparam int ADDR_W          = 12;
  localparam int DATA_W          = 16;
  localparam int CLK_PERIOD_NS   = 5;
  // Minimum phase time on the pins (setup, strobe, recovery), in ns
  localparam int PHASE_NS        = 40;
  localparam int PHASE_CYC_RAW   = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PHASE_CYC       = (PHASE_CYC_RAW < 1) ? 1 : PHASE_CYC_RAW;
  localparam int CNT_W           = 8;
  localparam logic [CNT_W-1:0] PHASE_LAST = CNT_W'(PHASE_CYC - 1);
  localparam logic [1:0] CMD_TAKE    = 2'h0;
  localparam logic [1:0] CMD_RELEASE = 2'h1;
  localparam logic [1:0] CMD_PEEK    = 2'h2;
  localparam logic [1:0] CMD_INIT    = 2'h3;
endpackage

// ### flag_port_host.sv
// Host controller driving one port's semaphore flag space
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Summary of operation
// - Select flag space, then strobe for writes; on reads OE falls in the same cycle as the flag select
// - Drop a strobe between polling reads
// - Take by write zero, then read back
// - After failure poll or withdraw request
// - Software writes one to all flags; CMD_INIT writes one to flags cmdIndex through the last
// ----------------------------------------------------------------------------
module flag_port_host
  import flag_host_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Command side
  input  wire logic              cmdValid,
  input  wire logic [1:0]        cmdOp,
  input  wire logic [INDEX_W-1:0] cmdIndex,
  input  wire logic              withdrawOnFail,
  output logic                   cmdReady,
  output logic                   doneValid,
  output logic                   doneOwned,
  // Device port pins
  output logic                   chipSelect_n,
  output logic                   flag_space_select_n,
  output logic                   readWrite,
  output logic                   outEnable_n,
  output logic [ADDR_W-1:0]      addr,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0]      dataOut,
  output logic                   dataOutEn
);

  typedef enum logic [3:0] {IDLE, WR_SET, WR_STB, WR_REC, RD_SET, RD_STB, RD_REC, DONE} state_t;

  state_t             state, next_state;
  logic [CNT_W-1:0]   cnt, next_cnt;
  logic [1:0]         op, next_op;
  logic [INDEX_W-1:0] idx, next_idx;
  logic               wbit, next_wbit;
  logic               wdraw, next_wdraw;
  logic               owned, next_owned;
  logic               retry, next_retry;
  logic               cmdReady_q, next_cmdReady;
  logic               doneValid_q, next_doneValid;
  logic               semN, next_semN, rw, next_rw, oeN, next_oeN, den, next_den;
  logic [ADDR_W-1:0]  addrQ, next_addrQ;
  logic [DATA_W-1:0]  dq, next_dq;
  logic               phaseEnd;

  assign phaseEnd = (cnt == PHASE_LAST);

  // ----------------------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_cnt       = phaseEnd ? '0 : cnt + CNT_W'(1);
    next_op        = op;
    next_idx       = idx;
    next_wbit      = wbit;
    next_wdraw     = wdraw;
    next_owned     = owned;
    next_retry     = retry;
    next_cmdReady  = 1'b0;
    next_doneValid = 1'b0;
    next_semN      = semN;
    next_rw        = rw;
    next_oeN       = oeN;
    next_den       = den;
    next_addrQ     = addrQ;
    next_dq        = dq;
    case (state)
      IDLE: begin
        next_cnt      = '0;
        next_cmdReady = 1'b1;
        next_semN     = 1'b1;
        next_oeN      = 1'b1;
        next_rw       = 1'b1;
        next_den      = 1'b0;
        if (cmdValid && cmdReady_q) begin
          next_cmdReady = 1'b0;
          next_op       = cmdOp;
          next_idx      = cmdIndex;
          next_wdraw    = withdrawOnFail;
          next_retry    = 1'b0;
          next_wbit     = (cmdOp == CMD_TAKE) ? 1'b0 : 1'b1;
          next_addrQ    = {{(ADDR_W-INDEX_W){1'b0}}, cmdIndex};
          next_state    = (cmdOp == CMD_PEEK) ? RD_SET : WR_SET;
        end
      end
      WR_SET: begin
        next_semN = 1'b0;
        next_rw   = 1'b1;
        next_den  = 1'b1;
        next_dq   = {DATA_W{wbit}};
        if (phaseEnd) next_state = WR_STB;
      end
      WR_STB: begin
        next_rw = 1'b0;
        if (phaseEnd) next_state = WR_REC;
      end
      WR_REC: begin
        next_rw   = 1'b1;
        next_semN = 1'b1;
        if (phaseEnd) begin
          next_den = 1'b0;
          if (op == CMD_TAKE) next_state = RD_SET;
          else if (op == CMD_INIT && idx != INDEX_W'(FLAG_COUNT - 1)) begin
            next_idx   = idx + INDEX_W'(1);
            next_addrQ = {{(ADDR_W-INDEX_W){1'b0}}, idx + INDEX_W'(1)};
            next_state = WR_SET;
          end else begin
            next_owned = 1'b0;
            next_state = DONE;
          end
        end
      end
      RD_SET: begin
        next_semN = 1'b0;
        next_rw   = 1'b1;
        next_oeN  = 1'b0;
        if (phaseEnd) next_state = RD_STB;
      end
      RD_STB: begin
        if (phaseEnd) begin
          next_owned = ~dataIn[0];
          next_oeN   = 1'b1;
          next_semN  = 1'b1;
          next_state = RD_REC;
        end
      end
      RD_REC: begin
        if (phaseEnd) begin
          if (op == CMD_TAKE && !owned && !wdraw) next_state = RD_SET;
          else if (op == CMD_TAKE && !owned && !retry) begin
            next_retry = 1'b1;
            next_wbit  = 1'b1;
            next_op    = CMD_RELEASE;
            next_state = WR_SET;
          end else next_state = DONE;
        end
      end
      DONE: begin
        next_doneValid = 1'b1;
        next_state     = IDLE;
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= IDLE; cnt <= '0; op <= CMD_PEEK; idx <= '0; wbit <= 1'b1;
      wdraw <= 1'b0; owned <= 1'b0; retry <= 1'b0; cmdReady_q <= 1'b0;
      doneValid_q <= 1'b0; semN <= 1'b1; rw <= 1'b1; oeN <= 1'b1; den <= 1'b0;
      addrQ <= '0; dq <= '0;
    end else begin
      state <= next_state; cnt <= next_cnt; op <= next_op; idx <= next_idx;
      wbit <= next_wbit; wdraw <= next_wdraw; owned <= next_owned; retry <= next_retry;
      cmdReady_q <= next_cmdReady; doneValid_q <= next_doneValid;
      semN <= next_semN; rw <= next_rw; oeN <= next_oeN; den <= next_den;
      addrQ <= next_addrQ; dq <= next_dq;
    end
  end

  assign chipSelect_n        = 1'b1;
  assign flag_space_select_n = semN;
  assign readWrite           = rw;
  assign outEnable_n         = oeN;
  assign addr                = addrQ;
  assign dataOut             = dq;
  assign dataOutEn           = den;
  assign cmdReady            = cmdReady_q;
  assign doneValid           = doneValid_q;
  assign doneOwned           = owned;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  property p_selfree;
    @(posedge clk) disable iff (!rst_b) state == IDLE |=> semN && oeN;
  endproperty
  a_selfree: assert property (p_selfree) else $error("flag select active while idle");

  property p_ramoff;
    @(posedge clk) disable iff (!rst_b) !semN |-> chipSelect_n && (rw || (den && oeN));
  endproperty
  a_ramoff: assert property (p_ramoff) else $error("ram select during flag access");

  property p_highaddr;
    @(posedge clk) disable iff (!rst_b) addrQ[ADDR_W-1:INDEX_W] == '0;
  endproperty
  a_highaddr: assert property (p_highaddr) else $error("upper address not zero");

  property p_repl;
    @(posedge clk) disable iff (!rst_b) den |-> (dq == {DATA_W{dq[0]}});
  endproperty
  a_repl: assert property (p_repl) else $error("write data not uniform");

  property p_noboth;
    @(posedge clk) disable iff (!rst_b) !(den && !oeN);
  endproperty
  a_noboth: assert property (p_noboth) else $error("drive during read");

  property p_wrfirst;
    @(posedge clk) disable iff (!rst_b)
      (state == IDLE && cmdValid && cmdReady_q && cmdOp == CMD_TAKE) |=> state == WR_SET;
  endproperty
  a_wrfirst: assert property (p_wrfirst) else $error("take did not write first");

  property p_gap;
    @(posedge clk) disable iff (!rst_b) $rose(state == RD_REC) |-> oeN && semN;
  endproperty
  a_gap: assert property (p_gap) else $error("strobes not dropped between reads");

  property p_take0;
    @(posedge clk) disable iff (!rst_b) (!rw && op == CMD_TAKE) |-> den && !semN && !dq[0];
  endproperty
  a_take0: assert property (p_take0) else $error("take wrote nonzero");

  c_take:  cover property (@(posedge clk) doneValid_q && owned);
  c_fail:  cover property (@(posedge clk) state == RD_REC && !owned && op == CMD_TAKE);
  c_init:  cover property (@(posedge clk) state == WR_REC && op == CMD_INIT && idx == 3'h7);
endmodule

// ### tb.sv
// Self-checking bench for the semaphore flag port controller
`timescale 1ns/100ps
module tb
  import flag_host_pkg::*;
;
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic               cmdValid = 1'b0;
  logic [1:0]         cmdOp = 2'h0;
  logic [INDEX_W-1:0] cmdIndex = 3'h0;
  logic               withdrawOnFail = 1'b0;
  logic               cmdReady, doneValid, doneOwned, chipSelect_n;
  logic               flag_space_select_n, readWrite, outEnable_n, dataOutEn;
  logic [ADDR_W-1:0]  addr;
  logic [DATA_W-1:0]  dataIn, dataOut;
  int                 bad_count = 0;
  int                 comparisons = 0;
  int                 cycles = 0;
  flag_port_host u_flag_port_host (.clk, .rst_b, .cmdValid, .cmdOp, .cmdIndex, .withdrawOnFail, .cmdReady,
    .doneValid, .doneOwned, .chipSelect_n, .flag_space_select_n, .readWrite, .outEnable_n, .addr, .dataIn,
    .dataOut, .dataOutEn);
  flag_device_model u_flag_device_model (.chipSelect_n, .flag_space_select_n, .readWrite, .outEnable_n,
    .addr, .dataIn, .dataOut, .dataOutEn);
  initial forever #2.5 clk = ~clk;
  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic check(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [DATA_W-1:0] rv(input bit r, input int i);
    return DATA_W'(u_flag_device_model.view(r, i[INDEX_W-1:0]));
  endfunction
  task automatic rw(input int i, input logic b);
    u_flag_device_model.write_right(i[INDEX_W-1:0], b);
  endtask
  task automatic do_cmd(input logic [1:0] op, input int i, input logic wd, input logic exp);
    while (cmdReady !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmdOp <= op;
    cmdIndex <= i[INDEX_W-1:0];
    withdrawOnFail <= wd;
    cmdValid <= 1'b1;
    @(posedge clk);
    cmdValid <= 1'b0;
    // A hang is caught by the cycle ceiling, never passed over
    do @(negedge clk); while (doneValid !== 1'b1);
    check("doneOwned", DATA_W'(doneOwned), DATA_W'(exp));
  endtask
  // Flag space cycles keep the RAM deselected and high address lines low
  always @(negedge clk)
    if (flag_space_select_n === 1'b0) check("selAddr", DATA_W'({chipSelect_n, addr[ADDR_W-1:INDEX_W]}), 16'h0200);
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic init_flags;
    for (int i = 0; i < FLAG_COUNT; i++) rw(i, 1'b1);
    do_cmd(CMD_INIT, 0, 1'b0, 1'b0);
    for (int i = 0; i < FLAG_COUNT; i++) check("initFree", rv(1'b0, i), 16'h0001);
  endtask
  task automatic take_release_each;
    for (int i = 0; i < FLAG_COUNT; i++) begin
      do_cmd(CMD_TAKE, i, 1'b0, 1'b1);
      check("rightSees", rv(1'b1, i), 16'h0001);
      rw(i, 1'b0);
      do_cmd(CMD_PEEK, i, 1'b0, 1'b1);
      do_cmd(CMD_RELEASE, i, 1'b0, 1'b0);
      check("handOver", rv(1'b1, i), 16'h0000);
      rw(i, 1'b1);
    end
  endtask
  task automatic withdraw_case;
    rw(2, 1'b0);
    do_cmd(CMD_TAKE, 2, 1'b1, 1'b0);
    rw(2, 1'b1);
    check("withdrawn", rv(1'b0, 2), 16'h0001);
  endtask
  task automatic poll_case;
    rw(6, 1'b0);
    fork
      do_cmd(CMD_TAKE, 6, 1'b0, 1'b1);
      begin
        repeat (200) @(posedge clk);
        rw(6, 1'b1);
      end
    join
    do_cmd(CMD_PEEK, 6, 1'b0, 1'b1);
    do_cmd(CMD_RELEASE, 6, 1'b0, 1'b0);
    do_cmd(CMD_PEEK, 6, 1'b0, 1'b0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    init_flags();
    take_release_each();
    withdraw_case();
    poll_case();
    tally_and_finish();
  end
endmodule
